// file: verilog/mges_status.sv
// global mode status register bank with AXI4-Lite slave and pad gating
// assumes sequencer inputs on CLK; oscillator levels may come from any domain
//
// What this block does
// (R1) current operating mode shown as a 4-bit code
// (R2) transition bit is 1 while a mode change runs, else 0
// (R3) consumption bit: 0 regulator may power down, 1 must stay on
// (R4) output power-down bit set when pads hi-z or pad driver off
// (R5) safe and test: pad outputs hi-z, pad driver off, inputs untouched
// (R6) stop: only the pad driver off, outputs keep their state
// (R7) standby: driver and non-wakeup pads unpowered, wakeup config kept
// (R8) regulator bit reads 1 when main regulator is ready
// (R9) data flash state as 2-bit code, 11 normal and usable
// (R10) code flash state with the same 2-bit coding
// (R11) pll bit reads 1 while the pll clock is stable
// (R12) crystal bit reads 1 while the crystal oscillator is stable
// (R13) internal rc bit reads 1 while that oscillator is stable
// (R14) active system clock source as 4-bit code
// (R15) transition-complete flag on 1 to 0 of transition, not into low power
// (R16) status readable as word, half-word or byte, big-endian order
// (R17) global status is read-only, writes ignored, fields live
//
// Local design decisions: register access over AXI4-Lite and the address map.

`timescale 1ns/10ps

module mges_status
(
    input wire logic CLK, // 10 MHz system clock
    input wire logic SRST, // synchronous reset, active high
    input mges_pkg::mges_seq_t SEQ_STATUS, // sequencer live state
    input mges_pkg::mges_osc_t OSC_STATUS, // oscillator levels, asynchronous
    input wire logic [11:0] S_AXI_AWADDR, // write address
    input wire logic S_AXI_AWVALID, // write address valid
    output logic S_AXI_AWREADY, // write address ready
    input wire logic [31:0] S_AXI_WDATA, // write data
    input wire logic [3:0] S_AXI_WSTRB, // write strobes
    input wire logic S_AXI_WVALID, // write data valid
    output logic S_AXI_WREADY, // write data ready
    output logic [1:0] S_AXI_BRESP, // write response
    output logic S_AXI_BVALID, // write response valid
    input wire logic S_AXI_BREADY, // write response ready
    input wire logic [11:0] S_AXI_ARADDR, // read address
    input wire logic S_AXI_ARVALID, // read address valid
    output logic S_AXI_ARREADY, // read address ready
    output logic [31:0] S_AXI_RDATA, // read data
    output logic [1:0] S_AXI_RRESP, // read response
    output logic S_AXI_RVALID, // read data valid
    input wire logic S_AXI_RREADY, // read data ready
    output mges_pkg::mges_pad_t PAD_CTRL, // pad gating controls
    output logic MTC_FLAG // transition-complete flag level
);
    import mges_pkg::*;

    // ----------------------------------------------------------------
    // oscillator synchronisers
    // ----------------------------------------------------------------

    mges_osc_t osc_meta;
    mges_osc_t osc_sync;

    // two flops before any logic looks at the oscillator levels
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            osc_meta <= '0;
            osc_sync <= '0;
        end
        else
        begin
            osc_meta <= OSC_STATUS;
            osc_sync <= osc_meta;
        end
    end

    // ----------------------------------------------------------------
    // pad gating per mode
    // ----------------------------------------------------------------

    mges_pad_t next_pad;
    mges_pad_t pad;
    logic pad_power_down;

    // decode the mode into hi-z, driver and non-wakeup power controls
    always_comb
    begin
        next_pad = '0;
        case (SEQ_STATUS.current_mode)
            MGES_MODE_SAFE, MGES_MODE_TEST:
            begin
                next_pad.out_hiz = 1'b1; // see (R5)
                next_pad.drv_off = 1'b1; // see (R5)
            end
            MGES_MODE_STOP:
            begin
                next_pad.drv_off = 1'b1; // see (R6)
            end
            MGES_MODE_STANDBY:
            begin
                next_pad.drv_off = 1'b1; // see (R7)
                next_pad.nonwake_off = 1'b1; // see (R7)
            end
            default:
            begin
                next_pad = '0;
            end
        endcase
    end

    // registered pad controls
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            pad <= '0;
        end
        else
        begin
            pad <= next_pad;
        end
    end

    // status bit follows any hi-z or driver-off gating
    assign pad_power_down = pad.out_hiz | pad.drv_off | pad.nonwake_off; // see (R4)

    // ----------------------------------------------------------------
    // live status word
    // ----------------------------------------------------------------

    mges_status_t next_status;
    mges_status_t status;

    // assemble the word; reserved bits read as zero
    always_comb
    begin
        next_status = '0;
        next_status.current_mode = SEQ_STATUS.current_mode; // see (R1)
        next_status.transition_in_progress = SEQ_STATUS.transition_in_progress; // see (R2)
        next_status.consumption_status = SEQ_STATUS.consumption_status; // see (R3)
        next_status.output_power_down_status = pad_power_down; // see (R4)
        next_status.regulator_ready_status = SEQ_STATUS.regulator_ready_status; // see (R8)
        next_status.data_flash_state = SEQ_STATUS.data_flash_state; // see (R9)
        next_status.code_flash_state = SEQ_STATUS.code_flash_state; // see (R10)
        next_status.pll_stable_status = osc_sync.pll_stable_status; // see (R11)
        next_status.crystal_osc_stable_status = osc_sync.crystal_osc_stable_status; // see (R12)
        next_status.internal_rc_stable_status = osc_sync.internal_rc_stable_status; // see (R13)
        next_status.system_clock_source = SEQ_STATUS.system_clock_source; // see (R14)
    end

    // status sampled every cycle, never written by software
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            status <= MGES_STATUS_RESET;
        end
        else
        begin
            status <= next_status; // see (R17)
        end
    end

    // ----------------------------------------------------------------
    // transition-complete flag
    // ----------------------------------------------------------------

    logic trans_prev;
    logic low_power_target;
    logic mtc_event;
    logic mtc_clear;

    // previous transition level for the falling edge
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            trans_prev <= 1'b0;
        end
        else
        begin
            trans_prev <= SEQ_STATUS.transition_in_progress;
        end
    end

    // no completion event when the transition enters a low-power mode
    assign low_power_target = (SEQ_STATUS.target_mode == MGES_MODE_HALT) ||
                              (SEQ_STATUS.target_mode == MGES_MODE_STOP) ||
                              (SEQ_STATUS.target_mode == MGES_MODE_STANDBY);
    assign mtc_event = trans_prev & ~SEQ_STATUS.transition_in_progress & ~low_power_target; // see (R15)

    // sticky flag, write one to clear, a new event wins over the clear
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            MTC_FLAG <= MGES_FLAG_RESET[MGES_FLAG_MTC_BIT];
        end
        else if (mtc_event)
        begin
            MTC_FLAG <= 1'b1; // see (R15)
        end
        else if (mtc_clear)
        begin
            MTC_FLAG <= 1'b0;
        end
    end

    assign PAD_CTRL = pad;

    // ----------------------------------------------------------------
    // axi4-lite write channel
    // ----------------------------------------------------------------

    logic aw_held;
    logic w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic write_go;

    // address and data taken in either order, held until the response
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            aw_held <= 1'b0;
            aw_addr <= '0;
            S_AXI_AWREADY <= 1'b1;
        end
        else if (S_AXI_AWVALID && S_AXI_AWREADY)
        begin
            aw_held <= 1'b1;
            aw_addr <= S_AXI_AWADDR;
            S_AXI_AWREADY <= 1'b0;
        end
        else if (S_AXI_BVALID && S_AXI_BREADY)
        begin
            aw_held <= 1'b0;
            S_AXI_AWREADY <= 1'b1;
        end
    end

    // write data capture
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
            S_AXI_WREADY <= 1'b1;
        end
        else if (S_AXI_WVALID && S_AXI_WREADY)
        begin
            w_held <= 1'b1;
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
            S_AXI_WREADY <= 1'b0;
        end
        else if (S_AXI_BVALID && S_AXI_BREADY)
        begin
            w_held <= 1'b0;
            S_AXI_WREADY <= 1'b1;
        end
    end

    assign write_go = aw_held & w_held & ~S_AXI_BVALID;

    // flag clear only through the byte lane that carries its bit
    assign mtc_clear = write_go && (aw_addr[11:2] == MGES_EVENT_FLAG_OFS[11:2]) &&
                       w_strb[0] && w_data[MGES_FLAG_MTC_BIT];

    // response once both halves are in; status writes are dropped
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= MGES_RESP_OKAY;
        end
        else if (write_go)
        begin
            S_AXI_BVALID <= 1'b1;
            if ((aw_addr[11:2] == MGES_GLOBAL_STATUS_OFS[11:2]) ||
                (aw_addr[11:2] == MGES_EVENT_FLAG_OFS[11:2]))
            begin
                S_AXI_BRESP <= MGES_RESP_OKAY; // see (R17)
            end
            else
            begin
                S_AXI_BRESP <= MGES_RESP_DECERR;
            end
        end
        else if (S_AXI_BREADY)
        begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite read channel
    // ----------------------------------------------------------------

    // whole word returned; narrow reads pick their lanes from it
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= '0;
            S_AXI_RRESP <= MGES_RESP_OKAY;
        end
        else if (S_AXI_ARVALID && S_AXI_ARREADY)
        begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP <= MGES_RESP_OKAY;
            if (S_AXI_ARADDR[11:2] == MGES_GLOBAL_STATUS_OFS[11:2])
            begin
                S_AXI_RDATA <= status; // see (R16)
            end
            else if (S_AXI_ARADDR[11:2] == MGES_EVENT_FLAG_OFS[11:2])
            begin
                S_AXI_RDATA <= {31'h0000_0000, MTC_FLAG};
            end
            else
            begin
                S_AXI_RDATA <= '0;
                S_AXI_RRESP <= MGES_RESP_DECERR;
            end
        end
        else if (S_AXI_RVALID && S_AXI_RREADY)
        begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
        end
    end

endmodule

// file: include/mges_pkg.sv
// package for the global mode status block: offsets, codes, field layout
// assumes a 32-bit AXI4-Lite register bus and a same-clock mode sequencer

package mges_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses, word aligned)
    // ----------------------------------------------------------------
    localparam logic [11:0] MGES_GLOBAL_STATUS_OFS = 12'h000;
    localparam logic [11:0] MGES_EVENT_FLAG_OFS = 12'h004;
    localparam logic [31:0] MGES_FLAG_RESET = 32'h0000_0000;
    localparam logic [31:0] MGES_STATUS_RESET = 32'h0000_0000;
    localparam int MGES_FLAG_MTC_BIT = 0;

    // ----------------------------------------------------------------
    // axi responses
    // ----------------------------------------------------------------
    localparam logic [1:0] MGES_RESP_OKAY = 2'h0;
    localparam logic [1:0] MGES_RESP_DECERR = 2'h3;

    // ----------------------------------------------------------------
    // device operating mode codes
    // ----------------------------------------------------------------
    localparam logic [3:0] MGES_MODE_RESET = 4'h0;
    localparam logic [3:0] MGES_MODE_TEST = 4'h1;
    localparam logic [3:0] MGES_MODE_SAFE = 4'h2;
    localparam logic [3:0] MGES_MODE_DEFAULT_RUN = 4'h3;
    localparam logic [3:0] MGES_MODE_RUN_0 = 4'h4;
    localparam logic [3:0] MGES_MODE_RUN_1 = 4'h5;
    localparam logic [3:0] MGES_MODE_RUN_2 = 4'h6;
    localparam logic [3:0] MGES_MODE_RUN_3 = 4'h7;
    localparam logic [3:0] MGES_MODE_HALT = 4'h8;
    localparam logic [3:0] MGES_MODE_STOP = 4'ha;
    localparam logic [3:0] MGES_MODE_STANDBY = 4'hd;

    // ----------------------------------------------------------------
    // system clock source and flash state codes
    // ----------------------------------------------------------------
    localparam logic [3:0] MGES_CLK_IRC = 4'h0;
    localparam logic [3:0] MGES_CLK_DIV_16M = 4'h1;
    localparam logic [3:0] MGES_CLK_XOSC = 4'h2;
    localparam logic [3:0] MGES_CLK_DIV_XOSC = 4'h3;
    localparam logic [3:0] MGES_CLK_PLL = 4'h4;
    localparam logic [1:0] MGES_FLASH_NONE = 2'h0;
    localparam logic [1:0] MGES_FLASH_POWER_DOWN = 2'h1;
    localparam logic [1:0] MGES_FLASH_LOW_POWER = 2'h2;
    localparam logic [1:0] MGES_FLASH_NORMAL = 2'h3;

    // live state delivered by the mode sequencer (same clock)
    typedef struct packed {
        logic [3:0] current_mode;
        logic [3:0] target_mode;
        logic transition_in_progress;
        logic consumption_status;
        logic regulator_ready_status;
        logic [1:0] data_flash_state;
        logic [1:0] code_flash_state;
        logic [3:0] system_clock_source;
    } mges_seq_t;

    // oscillator and pll stability levels (foreign domain, synchronised)
    typedef struct packed {
        logic pll_stable_status;
        logic crystal_osc_stable_status;
        logic internal_rc_stable_status;
    } mges_osc_t;

    // global status word, bit 31 first (bit 0 of the big-endian view)
    typedef struct packed {
        logic [3:0] current_mode;
        logic transition_in_progress;
        logic consumption_status;
        logic rsv_a;
        logic output_power_down_status;
        logic [2:0] rsv_b;
        logic regulator_ready_status;
        logic [1:0] data_flash_state;
        logic [1:0] code_flash_state;
        logic [7:0] rsv_c;
        logic pll_stable_status;
        logic crystal_osc_stable_status;
        logic internal_rc_stable_status;
        logic rsv_d;
        logic [3:0] system_clock_source;
    } mges_status_t;

    // pad power gating controls
    typedef struct packed {
        logic out_hiz;
        logic drv_off;
        logic nonwake_off;
    } mges_pad_t;

endpackage

// file: dv/mges_status_props.sv
// checker for the global mode status block: bus answers, pad gating, flag
// assumes binding onto mges_status, one clock CLK, synchronous reset SRST
`timescale 1ns/10ps
module mges_status_props
(
    input wire logic CLK, // system clock
    input wire logic SRST, // sync reset
    input mges_pkg::mges_seq_t SEQ_STATUS, // sequencer state
    input wire logic S_AXI_AWVALID, // aw valid
    input wire logic S_AXI_AWREADY, // aw ready
    input wire logic S_AXI_WVALID, // w valid
    input wire logic S_AXI_WREADY, // w ready
    input wire logic [1:0] S_AXI_BRESP, // b response
    input wire logic S_AXI_BVALID, // b valid
    input wire logic S_AXI_BREADY, // b ready
    input wire logic S_AXI_ARVALID, // ar valid
    input wire logic S_AXI_ARREADY, // ar ready
    input wire logic [31:0] S_AXI_RDATA, // read data
    input wire logic S_AXI_RVALID, // r valid
    input wire logic S_AXI_RREADY, // r ready
    input mges_pkg::mges_pad_t PAD_CTRL, // pad gating
    input wire logic MTC_FLAG // transition-complete flag
);
    import mges_pkg::*;
    // --------
    // helpers
    // --------
    logic tip, lp_tgt, hiz_m, off_m, sb_m, wr_idle;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SRST);
    // decode of the live mode and target
    assign tip = SEQ_STATUS.transition_in_progress;
    assign lp_tgt = SEQ_STATUS.target_mode inside {MGES_MODE_HALT, MGES_MODE_STOP, MGES_MODE_STANDBY};
    assign hiz_m = SEQ_STATUS.current_mode inside {MGES_MODE_SAFE, MGES_MODE_TEST};
    assign off_m = hiz_m || (SEQ_STATUS.current_mode inside {MGES_MODE_STOP, MGES_MODE_STANDBY});
    assign sb_m = SEQ_STATUS.current_mode == MGES_MODE_STANDBY;
    assign wr_idle = S_AXI_AWREADY && S_AXI_WREADY && !S_AXI_AWVALID && !S_AXI_WVALID;
    // --------
    // assertions
    // --------
    AST_PAD_HIZ: assert property (!$past(SRST) |-> PAD_CTRL.out_hiz == $past(hiz_m))
        else $error("pad hi-z does not follow safe or test mode");
    AST_PAD_DRV: assert property (!$past(SRST) |-> PAD_CTRL.drv_off == $past(off_m))
        else $error("pad driver gating wrong for mode");
    AST_PAD_SB: assert property (!$past(SRST) |-> PAD_CTRL.nonwake_off == $past(sb_m))
        else $error("non-wakeup pad gating wrong for mode");
    AST_MTC_SET: assert property (!$past(SRST) && $fell(tip) && !lp_tgt |=> MTC_FLAG)
        else $error("flag not raised at end of transition");
    AST_MTC_LP: assert property (!$past(SRST) && $fell(tip) && lp_tgt && !MTC_FLAG |=> !MTC_FLAG)
        else $error("flag raised on entry to low power");
    AST_MTC_KEEP: assert property (MTC_FLAG && wr_idle |=> MTC_FLAG)
        else $error("flag dropped without a write");
    AST_RD_ANSWER: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
        else $error("read answer not one cycle after address");
    AST_RD_HOLD: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data not held until taken");
    AST_WR_ANSWER: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
        else $error("write response late");
    AST_WR_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response not held until taken");
    // main scenarios reached
    COV_MTC: cover property ($fell(tip) && !lp_tgt);
    COV_SB: cover property (PAD_CTRL.nonwake_off);
    COV_WR: cover property (S_AXI_BVALID && S_AXI_BREADY);
endmodule

bind mges_status mges_status_props u_props (.CLK(CLK), .SRST(SRST), .SEQ_STATUS(SEQ_STATUS),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
    .PAD_CTRL(PAD_CTRL), .MTC_FLAG(MTC_FLAG));

// file: dv/tb_mges_status.sv
// testbench for the global mode status block: status table, bus, flag
// assumes the package, the design and its checker are compiled first
`timescale 1ns/10ps
module tb_mges_status;
    import mges_pkg::*;
    // --------
    // signals
    // --------
    logic clk, srst, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, mtc;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, got, exp;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    mges_seq_t seq;
    mges_osc_t osc;
    mges_pad_t pad;
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;
    // mode beside expected out_hiz, drv_off, nonwake_off
    localparam logic [6:0] ROWS [12] = '{{MGES_MODE_RESET, 3'b000}, {MGES_MODE_TEST, 3'b110},
        {MGES_MODE_SAFE, 3'b110}, {MGES_MODE_DEFAULT_RUN, 3'b000}, {MGES_MODE_RUN_0, 3'b000},
        {MGES_MODE_RUN_1, 3'b000}, {MGES_MODE_RUN_2, 3'b000}, {MGES_MODE_RUN_3, 3'b000},
        {MGES_MODE_HALT, 3'b000}, {MGES_MODE_STOP, 3'b010}, {MGES_MODE_STANDBY, 3'b011}, {4'hf, 3'b000}};
    localparam logic [3:0] TGT [4] = '{MGES_MODE_DEFAULT_RUN, MGES_MODE_HALT, MGES_MODE_STOP, MGES_MODE_STANDBY};

    mges_status dut (.CLK(clk), .SRST(srst), .SEQ_STATUS(seq), .OSC_STATUS(osc),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .PAD_CTRL(pad), .MTC_FLAG(mtc));

    // clock of 100 ns period
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // --------
    // tasks
    // --------
    task automatic check(input string what, input logic [31:0] e, input logic [31:0] seen);
        tests_run++;
        if (seen !== e)
        begin
            $display("wrong value %s expected %h seen %h", what, e, seen);
            n_mismatch++;
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // read one word; ready raised late so the slave must hold its answer
    task automatic rd(input logic [11:0] a);
        @(posedge clk);
        arvalid <= 1'b1;
        araddr <= a;
        do @(negedge clk); while (!arready);
        @(posedge clk);
        arvalid <= 1'b0;
        do @(negedge clk); while (!rvalid);
        @(posedge clk);
        rready <= 1'b1;
        @(negedge clk);
        got = rdata;
        resp = rresp;
        @(posedge clk);
        rready <= 1'b0;
    endtask

    // write one word; address and data offered together, each released when taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic aw_done, w_done, aw_hit, w_hit;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge clk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hf;
        while (!(aw_done && w_done))
        begin
            @(negedge clk);
            aw_hit = !aw_done && awready;
            w_hit = !w_done && wready;
            @(posedge clk);
            if (aw_hit)
                awvalid <= 1'b0;
            if (w_hit)
                wvalid <= 1'b0;
            aw_done = aw_done || aw_hit;
            w_done = w_done || w_hit;
        end
        do @(negedge clk); while (!bvalid);
        @(posedge clk);
        bready <= 1'b1;
        @(negedge clk);
        resp = bresp;
        @(posedge clk);
        bready <= 1'b0;
    endtask

    // hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_mismatch++;
            wrap_up();
        end
    end

    // --------
    // main sequence
    // --------
    initial
    begin
        srst = 1'b1;
        seq = '0;
        osc = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = '0;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        check("pad after reset", 32'h0, {29'h0, pad});
        check("flag after reset", 32'h0, {31'h0, mtc});
        check("bus after reset", 32'h1c, {27'h0, arready, awready, wready, bvalid, rvalid});
        $display("test reset done");
        // table of modes with the other fields stepped along
        for (int i = 0; i < 12; i++)
        begin
            @(posedge clk);
            seq <= {ROWS[i][6:3], ROWS[i][6:3], i[0], i[1], i[2], i[1:0], i[1:0] + 2'h1, 4'(i % 5)};
            osc <= i[2:0];
            exp = {ROWS[i][6:3], i[0], i[1], 1'b0, |ROWS[i][2:0], 3'h0, i[2], i[1:0], i[1:0] + 2'h1,
                8'h0, i[2:0], 1'b0, 4'(i % 5)};
            repeat (4) @(posedge clk);
            rd(MGES_GLOBAL_STATUS_OFS);
            check("status word", exp, got);
            check("pad gating", {29'h0, ROWS[i][2:0]}, {29'h0, pad});
        end
        $display("test status table done");
        // write to the status word is answered but changes nothing
        wr(MGES_GLOBAL_STATUS_OFS, 32'hffff_ffff);
        check("status write resp", {30'h0, MGES_RESP_OKAY}, {30'h0, resp});
        rd(MGES_GLOBAL_STATUS_OFS);
        check("status after write", exp, got);
        rd(12'h008);
        check("unmapped resp", {30'h0, MGES_RESP_DECERR}, {30'h0, resp});
        check("unmapped data", 32'h0, got);
        wr(12'h008, 32'h0);
        check("unmapped write resp", {30'h0, MGES_RESP_DECERR}, {30'h0, resp});
        $display("test write and unmapped done");
        // end of transition into each target, flag then cleared
        wr(MGES_EVENT_FLAG_OFS, 32'h1);
        for (int t = 0; t < 4; t++)
        begin
            @(posedge clk);
            seq.target_mode <= TGT[t];
            seq.transition_in_progress <= 1'b1;
            repeat (2) @(posedge clk);
            seq.transition_in_progress <= 1'b0;
            repeat (3) @(posedge clk);
            rd(MGES_EVENT_FLAG_OFS);
            check("flag register", {31'h0, t == 0}, got);
            wr(MGES_EVENT_FLAG_OFS, 32'h1);
            check("flag after clear", 32'h0, {31'h0, mtc});
        end
        $display("test transition flag done");
        // second reset while in standby clears the pad gating
        @(posedge clk);
        seq.current_mode <= MGES_MODE_STANDBY;
        repeat (3) @(posedge clk);
        check("pad before reset", 32'h3, {29'h0, pad});
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check("pad in reset", 32'h0, {29'h0, pad});
        @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        check("pad at release", 32'h0, {29'h0, pad});
        check("bus at release", 32'h1c, {27'h0, arready, awready, wready, bvalid, rvalid});
        @(negedge clk);
        check("pad after release", 32'h3, {29'h0, pad});
        repeat (3) @(posedge clk);
        $display("test second reset done");
        wrap_up();
    end
endmodule
